// ### hw/pin_sync3.sv
// Three-stage synchroniser for a pin input with agreement filter.
// Assumes the pin is asynchronous to clk; output changes once stages two and three agree.
`timescale 1ns/1ns
module pin_sync3 (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pin_in,
  output logic      level_r
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // Shift chain; first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_r = st_r.q;

endmodule : pin_sync3

// ### hw/rfid_status_test_regs.sv
// Status and test register group: clash position, signal strength, analog test control.
// Assumes a host register port on clk, framing events and strength codes on clk,
// and asynchronous pins for chip enable, oscillator running and on-off keying.
`timescale 1ns/1ns

// Behaviour
// R1 - Position register zero at reset, clears after read
// R2 - Position holds low eight bits of position
// R3 - Non type A: position of frame errors
// R4 - Strength valid from receive start to transmit
// R5 - Strength latches peak of demodulated envelope
// R6 - Latched strength cleared at next transmit
// R7 - Strength is 3-bit code, 4 dB steps
// R8 - Main in bits 2:0, auxiliary 5:3
// R9 - Auxiliary measures secondary input unless swapped
// R10 - Bit 6 flags oscillator stable after 200us
// R11 - Test register zero at reset or disable
// R12 - Test bit 7: keying pin feeds decoder
// R13 - Test bit 6: modulation pin outputs subcarrier
// R14 - Test bit 5: direct keying plus receiver reset
// R15 - Test bit 4 selects receiver stage
// R16 - Test bits 3,2 cut stage gain
// R17 - Test bit 0: gain level on main bits
// R18 - Test bit 1 enables input follower test
// R19 - Unused status bit zero, writes ignored
module rfid_status_test_regs #(
  parameter int OSC_STABLE_CYCLES = rfid_status_pkg::OSC_STABLE_CYC
) (
  input  wire logic                                 clk,
  input  wire logic                                 srst,
  input  wire logic                                 chip_enable_pin,
  input  wire logic [rfid_status_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                                 reg_wr_en,
  input  wire logic [rfid_status_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                                 reg_rd_en,
  output logic      [rfid_status_pkg::DATA_W-1:0]   reg_rdata_r,
  input  wire logic                                 type_a_mode,
  input  wire logic                                 collision_valid,
  input  wire logic                                 error_valid,
  input  wire logic [rfid_status_pkg::DATA_W-1:0]   bit_position,
  input  wire logic                                 tx_start,
  input  wire logic                                 rx_start,
  input  wire logic [rfid_status_pkg::STRENGTH_W-1:0] primary_receive_input,
  input  wire logic [rfid_status_pkg::STRENGTH_W-1:0] secondary_receive_input,
  input  wire logic                                 swap_inputs,
  input  wire logic [rfid_status_pkg::STRENGTH_W-1:0] agc_level,
  input  wire logic                                 osc_running_pin,
  input  wire logic                                 onoff_keying_pin,
  input  wire logic                                 rx_subcarrier,
  input  wire logic                                 tx_modulation,
  output logic                                      keying_control_pin,
  output logic                                      decoder_data,
  output logic                                      decoder_digital_input_select,
  output logic                                      subcarrier_output_select,
  output logic                                      direct_keying_select,
  output logic                                      receiver_reset,
  output logic                                      stage_select,
  output logic                                      second_stage_gain_cut,
  output logic                                      first_stage_gain_cut,
  output logic                                      follower_test,
  output logic                                      gain_loop_test
);

  typedef struct packed {
    logic [rfid_status_pkg::DATA_W-1:0]    clash;
    logic [rfid_status_pkg::DATA_W-1:0]    test;
    logic [rfid_status_pkg::DATA_W-1:0]    rdata;
    logic                                  rx_active;
    logic [rfid_status_pkg::OSC_CNT_W-1:0] osc_cnt;
    logic                                  osc_ok;
    logic                                  keying_pin;
    logic                                  dec_data;
  } regs_state_t;

  localparam regs_state_t ST_RST = '{
    clash:      rfid_status_pkg::CLASH_RST,
    test:       rfid_status_pkg::TEST_RST,
    rdata:      rfid_status_pkg::RDATA_RST,
    rx_active:  1'b0,
    osc_cnt:    '0,
    osc_ok:     1'b0,
    keying_pin: 1'b0,
    dec_data:   1'b0
  };

  localparam logic [rfid_status_pkg::OSC_CNT_W-1:0] OSC_LIMIT =
    rfid_status_pkg::OSC_CNT_W'(OSC_STABLE_CYCLES);

  regs_state_t st_r;
  regs_state_t st_nxt;

  logic                                      en_q;
  logic                                      osc_run_q;
  logic                                      keying_in_q;
  logic                                      peak_clear;
  logic                                      clash_event;
  logic [rfid_status_pkg::STRENGTH_W-1:0]    aux_source;
  logic [rfid_status_pkg::STRENGTH_W-1:0]    main_peak_r;
  logic [rfid_status_pkg::STRENGTH_W-1:0]    aux_peak_r;
  logic [rfid_status_pkg::STRENGTH_W-1:0]    main_field;
  logic [rfid_status_pkg::DATA_W-1:0]        status_word;

  // Pin inputs
  pin_sync3 u_en_sync (
    .clk     (clk),
    .srst    (srst),
    .pin_in  (chip_enable_pin),
    .level_r (en_q)
  );

  pin_sync3 u_osc_sync (
    .clk     (clk),
    .srst    (srst),
    .pin_in  (osc_running_pin),
    .level_r (osc_run_q)
  );

  pin_sync3 u_keying_sync (
    .clk     (clk),
    .srst    (srst),
    .pin_in  (onoff_keying_pin),
    .level_r (keying_in_q)
  );

  // Strength peaks, cleared by transmit or disable
  assign peak_clear = tx_start | ~en_q;                                    // [R6]
  assign aux_source = swap_inputs ? primary_receive_input                  // [R9]
                                  : secondary_receive_input;

  strength_peak u_main_peak (
    .clk    (clk),
    .srst   (srst),
    .clear  (peak_clear),
    .track  (st_r.rx_active | rx_start),                                   // [R4] [R5]
    .level  (primary_receive_input),
    .peak_r (main_peak_r)
  );

  strength_peak u_aux_peak (
    .clk    (clk),
    .srst   (srst),
    .clear  (peak_clear),
    .track  (st_r.rx_active | rx_start),                                   // [R4] [R5]
    .level  (aux_source),
    .peak_r (aux_peak_r)
  );

  // Status word assembly
  assign main_field  = st_r.test[rfid_status_pkg::AGC_TEST_BIT] ? agc_level : main_peak_r; // [R17]
  assign status_word = {1'b0, st_r.osc_ok, aux_peak_r, main_field};      // [R7] [R8] [R10] [R19]

  // Clash source depends on protocol
  assign clash_event = type_a_mode ? collision_valid : error_valid;       // [R3]

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = rfid_status_pkg::RDATA_RST;

    // Register reads, unmapped addresses read zero
    if (reg_rd_en) begin
      unique case (reg_addr)
        rfid_status_pkg::CLASH_OFF:    st_nxt.rdata = st_r.clash;
        rfid_status_pkg::STRENGTH_OFF: st_nxt.rdata = status_word;
        rfid_status_pkg::TEST_OFF:     st_nxt.rdata = st_r.test;
        default:                       st_nxt.rdata = rfid_status_pkg::RDATA_RST;
      endcase
    end

    // Clash position: read clears, new event wins
    if (reg_rd_en && (reg_addr == rfid_status_pkg::CLASH_OFF)) begin
      st_nxt.clash = rfid_status_pkg::CLASH_RST;                           // [R1]
    end
    if (clash_event) begin
      st_nxt.clash = bit_position;                                         // [R2] [R3]
    end

    // Test register; strength register ignores writes
    if (reg_wr_en && (reg_addr == rfid_status_pkg::TEST_OFF)) begin
      st_nxt.test = reg_wdata;                                             // [R19]
    end

    // Receive window, transmit ends it
    if (rx_start) begin
      st_nxt.rx_active = 1'b1;                                             // [R4]
    end
    if (tx_start) begin
      st_nxt.rx_active = 1'b0;                                             // [R6]
    end

    // Oscillator settle counter
    if (!osc_run_q) begin
      st_nxt.osc_cnt = '0;
      st_nxt.osc_ok  = 1'b0;
    end else if (st_r.osc_cnt >= OSC_LIMIT) begin
      st_nxt.osc_ok  = 1'b1;                                               // [R10]
    end else begin
      st_nxt.osc_cnt = st_r.osc_cnt + 1'b1;
    end

    // Pin routing
    st_nxt.keying_pin = st_r.test[rfid_status_pkg::SUB_OUT_BIT] ? rx_subcarrier   // [R13]
                                                                : tx_modulation;  // [R14]
    st_nxt.dec_data   = st_r.test[rfid_status_pkg::DEC_IN_BIT] ? keying_in_q      // [R12]
                                                               : rx_subcarrier;

    // Chip disabled holds contents at reset value
    if (!en_q) begin
      st_nxt.clash     = rfid_status_pkg::CLASH_RST;                       // [R1]
      st_nxt.test      = rfid_status_pkg::TEST_RST;                        // [R11]
      st_nxt.rx_active = 1'b0;
      st_nxt.osc_cnt   = '0;
      st_nxt.osc_ok    = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= ST_RST;                                                      // [R1] [R11]
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_r                  = st_r.rdata;
  assign keying_control_pin           = st_r.keying_pin;
  assign decoder_data                 = st_r.dec_data;
  assign decoder_digital_input_select = st_r.test[rfid_status_pkg::DEC_IN_BIT];    // [R12]
  assign subcarrier_output_select     = st_r.test[rfid_status_pkg::SUB_OUT_BIT];   // [R13]
  assign direct_keying_select         = st_r.test[rfid_status_pkg::DIRECT_BIT];    // [R14]
  assign receiver_reset               = st_r.test[rfid_status_pkg::DIRECT_BIT];    // [R14]
  assign stage_select                 = st_r.test[rfid_status_pkg::STAGE_SEL_BIT]; // [R15]
  assign second_stage_gain_cut        = st_r.test[rfid_status_pkg::GAIN2_BIT];     // [R16]
  assign first_stage_gain_cut         = st_r.test[rfid_status_pkg::GAIN1_BIT];     // [R16]
  assign follower_test                = st_r.test[rfid_status_pkg::FOLLOW_BIT];    // [R18]
  assign gain_loop_test               = st_r.test[rfid_status_pkg::AGC_TEST_BIT];  // [R17]

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_clash_read_clear: assert property ( // [R1]
    (reg_rd_en && reg_addr == rfid_status_pkg::CLASH_OFF && !clash_event)
      |=> (st_r.clash == rfid_status_pkg::CLASH_RST)
  ) else $error("clash position not cleared after read");

  a_clash_read_data: assert property ( // [R1]
    (reg_rd_en && reg_addr == rfid_status_pkg::CLASH_OFF)
      |=> (reg_rdata_r == $past(st_r.clash))
  ) else $error("clash read returned wrong value");

  a_clash_event_load: assert property ( // [R2]
    (clash_event && en_q) |=> (st_r.clash == $past(bit_position))
  ) else $error("clash position not captured");

  a_error_source: assert property ( // [R3]
    (!type_a_mode && error_valid && !collision_valid && en_q)
      |=> (st_r.clash == $past(bit_position))
  ) else $error("error position not captured outside type A");

  a_peak_clear_tx: assert property ( // [R6]
    tx_start |=> (main_peak_r == rfid_status_pkg::STRENGTH_RST)
                 && (aux_peak_r == rfid_status_pkg::STRENGTH_RST)
  ) else $error("strength not cleared on transmit");

  a_peak_hold: assert property ( // [R5]
    (!peak_clear && $past(!peak_clear) && st_r.rx_active) |-> (main_peak_r >= $past(main_peak_r))
  ) else $error("main strength peak dropped during reception");

  a_peak_stable_idle: assert property ( // [R4]
    (!st_r.rx_active && !rx_start && !peak_clear) [*2] |-> $stable(aux_peak_r)
  ) else $error("auxiliary strength changed outside receive window");

  a_status_layout: assert property ( // [R8]
    (reg_rd_en && reg_addr == rfid_status_pkg::STRENGTH_OFF)
      |=> (reg_rdata_r[rfid_status_pkg::UNUSED_BIT] == 1'b0)
          && (reg_rdata_r[5:3] == $past(aux_peak_r))
  ) else $error("strength status layout wrong");

  a_agc_override: assert property ( // [R17]
    (reg_rd_en && reg_addr == rfid_status_pkg::STRENGTH_OFF && gain_loop_test)
      |=> (reg_rdata_r[2:0] == $past(agc_level))
  ) else $error("gain level not shown on main bits");

  a_osc_ok_cause: assert property ( // [R10]
    $rose(st_r.osc_ok) |-> ($past(st_r.osc_cnt) == OSC_LIMIT) && $past(osc_run_q)
  ) else $error("oscillator stable flag raised early");

  a_test_disable: assert property ( // [R11]
    !en_q |=> (st_r.test == rfid_status_pkg::TEST_RST)
  ) else $error("test register not cleared while disabled");

  a_ro_write_ignored: assert property ( // [R19]
    (reg_wr_en && reg_addr == rfid_status_pkg::STRENGTH_OFF && en_q) |=> $stable(st_r.test)
  ) else $error("write to read-only register changed state");

  a_keying_route: assert property ( // [R13]
    subcarrier_output_select |=> (keying_control_pin == $past(rx_subcarrier))
  ) else $error("modulation pin not carrying subcarrier");

  a_decoder_route: assert property ( // [R12]
    decoder_digital_input_select |=> (decoder_data == $past(keying_in_q))
  ) else $error("decoder not fed from keying pin");

  a_main_peak_track: assert property ( // [R5]
    (rx_start && !peak_clear && (primary_receive_input > main_peak_r))
      |=> (main_peak_r == $past(primary_receive_input))
  ) else $error("main strength peak not taken from reception start");

  a_aux_default_source: assert property ( // [R9]
    ((st_r.rx_active || rx_start) && !peak_clear && !swap_inputs && (secondary_receive_input > aux_peak_r))
      |=> (aux_peak_r == $past(secondary_receive_input))
  ) else $error("auxiliary strength not measuring secondary input");

  a_aux_swap_source: assert property ( // [R9]
    ((st_r.rx_active || rx_start) && !peak_clear && swap_inputs && (primary_receive_input > aux_peak_r))
      |=> (aux_peak_r == $past(primary_receive_input))
  ) else $error("auxiliary strength not measuring primary input when swapped");

  a_direct_keying: assert property ( // [R14]
    (reg_wr_en && reg_addr == rfid_status_pkg::TEST_OFF && en_q)
      |=> (direct_keying_select == $past(reg_wdata[rfid_status_pkg::DIRECT_BIT]))
          && (receiver_reset == $past(reg_wdata[rfid_status_pkg::DIRECT_BIT]))
  ) else $error("direct keying bit not driving keying select and receiver reset");

  a_test_write_fields: assert property ( // [R15] [R16] [R18]
    (reg_wr_en && reg_addr == rfid_status_pkg::TEST_OFF && en_q)
      |=> ({stage_select, second_stage_gain_cut, first_stage_gain_cut, follower_test}
           == $past(reg_wdata[rfid_status_pkg::STAGE_SEL_BIT:rfid_status_pkg::FOLLOW_BIT]))
  ) else $error("receiver stage controls do not follow test register");

  a_keying_default: assert property ( // [R14]
    !subcarrier_output_select |=> (keying_control_pin == $past(tx_modulation))
  ) else $error("modulation pin not carrying transmit modulation");

  a_osc_ok_drop: assert property ( // [R10]
    !osc_run_q |=> !st_r.osc_ok
  ) else $error("oscillator stable flag kept after oscillator stopped");

  c_clash_read:   cover property (clash_event ##[1:20] (reg_rd_en && reg_addr == rfid_status_pkg::CLASH_OFF));
  c_rx_then_tx:   cover property (rx_start ##[1:50] tx_start);
  c_osc_ready:    cover property ($rose(st_r.osc_ok));
  c_test_written: cover property (reg_wr_en && reg_addr == rfid_status_pkg::TEST_OFF && en_q);
  c_swapped_read: cover property (swap_inputs && reg_rd_en && reg_addr == rfid_status_pkg::STRENGTH_OFF);

endmodule : rfid_status_test_regs

// ### hw/strength_peak.sv
// Peak latch for one receive strength channel.
// Assumes level codes arrive on clk; clear outranks tracking.
`timescale 1ns/1ns
module strength_peak (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       clear,
  input  wire logic       track,
  input  wire logic [2:0] level,
  output logic      [2:0] peak_r
);

  typedef struct packed {
    logic [2:0] peak;
  } peak_state_t;

  peak_state_t st_r;
  peak_state_t st_nxt;

  // Hold the largest code seen while track is high since the last clear
  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.peak = rfid_status_pkg::STRENGTH_RST;
    end else if (track && (level > st_r.peak)) begin
      st_nxt.peak = level;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r.peak <= rfid_status_pkg::STRENGTH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign peak_r = st_r.peak;

endmodule : strength_peak

// ### pkg/rfid_status_pkg.sv
// Constants shared by the status and test register group of the reader front end.
// Assumes a 100 MHz core clock and a host register port with 5-bit addresses.
package rfid_status_pkg;

  // Register port geometry
  localparam int ADDR_W     = 5;
  localparam int DATA_W     = 8;
  localparam int STRENGTH_W = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] CLASH_OFF    = 5'h0E;
  localparam logic [ADDR_W-1:0] STRENGTH_OFF = 5'h0F;
  localparam logic [ADDR_W-1:0] TEST_OFF     = 5'h1A;

  // Values after reset or chip disable
  localparam logic [DATA_W-1:0]     CLASH_RST    = 8'h00;
  localparam logic [DATA_W-1:0]     TEST_RST     = 8'h00;
  localparam logic [DATA_W-1:0]     RDATA_RST    = 8'h00;
  localparam logic [STRENGTH_W-1:0] STRENGTH_RST = 3'h0;

  // Test register fields
  localparam int DEC_IN_BIT    = 7;
  localparam int SUB_OUT_BIT   = 6;
  localparam int DIRECT_BIT    = 5;
  localparam int STAGE_SEL_BIT = 4;
  localparam int GAIN2_BIT     = 3;
  localparam int GAIN1_BIT     = 2;
  localparam int FOLLOW_BIT    = 1;
  localparam int AGC_TEST_BIT  = 0;

  // Strength status fields
  localparam int UNUSED_BIT = 7;
  localparam int OSC_OK_BIT = 6;
  localparam int AUX_LSB    = 3;
  localparam int MAIN_LSB   = 0;

  // Strength step size, one code step per increment
  localparam int STRENGTH_STEP_DB = 4;

  // Oscillator settle time
  localparam int CLK_MHZ        = 100;
  localparam int OSC_STABLE_US  = 200;
  localparam int OSC_STABLE_CYC = OSC_STABLE_US * CLK_MHZ;
  localparam int OSC_CNT_W      = 16;

endpackage : rfid_status_pkg

// ### verification/host_reg_model.sv
// Host side of the register port: single byte write and read cycles.
// Assumes one-cycle strobes and read data registered on the cycle after the read strobe.
`timescale 1ns/1ns
module host_reg_model (
  input  wire logic                               clk,
  output logic      [rfid_status_pkg::ADDR_W-1:0] reg_addr,
  output logic                                    reg_wr_en,
  output logic      [rfid_status_pkg::DATA_W-1:0] reg_wdata,
  output logic                                    reg_rd_en,
  input  wire logic [rfid_status_pkg::DATA_W-1:0] reg_rdata_r
);
  initial begin
    reg_addr  = 5'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end

  // Write strobe held for exactly one edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // Read data taken in the cycle after the strobe edge
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    d = reg_rdata_r;
  endtask : rd
endmodule : host_reg_model

// ### verification/rfid_status_test_regs_tb_top.sv
// Self-checking bench for the status and test register group.
// Assumes the host model drives the register port; events and codes come from here.
`timescale 1ns/1ns
module rfid_status_test_regs_tb_top;
  localparam int OSC_CYC = 20;
  logic       clk, srst, chip_enable_pin, reg_wr_en, reg_rd_en, type_a_mode;
  logic       collision_valid, error_valid, tx_start, rx_start, swap_inputs;
  logic       osc_running_pin, onoff_keying_pin, rx_subcarrier, tx_modulation;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_r, bit_position;
  logic [2:0] primary_receive_input, secondary_receive_input, agc_level;
  logic       keying_control_pin, decoder_data, decoder_digital_input_select;
  logic       subcarrier_output_select, direct_keying_select, receiver_reset, stage_select;
  logic       second_stage_gain_cut, first_stage_gain_cut, follower_test, gain_loop_test;
  logic [7:0] outs;
  int         errors;
  int         n_checks;

  assign outs = {decoder_digital_input_select, subcarrier_output_select, direct_keying_select,
                 stage_select, second_stage_gain_cut, first_stage_gain_cut, follower_test,
                 gain_loop_test};

  rfid_status_test_regs #(.OSC_STABLE_CYCLES(OSC_CYC)) rfid_status_test_regs_inst (
    .clk(clk), .srst(srst), .chip_enable_pin(chip_enable_pin), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata_r(reg_rdata_r),
    .type_a_mode(type_a_mode), .collision_valid(collision_valid), .error_valid(error_valid),
    .bit_position(bit_position), .tx_start(tx_start), .rx_start(rx_start),
    .primary_receive_input(primary_receive_input), .secondary_receive_input(secondary_receive_input),
    .swap_inputs(swap_inputs), .agc_level(agc_level), .osc_running_pin(osc_running_pin),
    .onoff_keying_pin(onoff_keying_pin), .rx_subcarrier(rx_subcarrier), .tx_modulation(tx_modulation),
    .keying_control_pin(keying_control_pin), .decoder_data(decoder_data),
    .decoder_digital_input_select(decoder_digital_input_select),
    .subcarrier_output_select(subcarrier_output_select), .direct_keying_select(direct_keying_select),
    .receiver_reset(receiver_reset), .stage_select(stage_select),
    .second_stage_gain_cut(second_stage_gain_cut), .first_stage_gain_cut(first_stage_gain_cut),
    .follower_test(follower_test), .gain_loop_test(gain_loop_test)
  );

  host_reg_model host_reg_model_inst (
    .clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata_r(reg_rdata_r)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    host_reg_model_inst.rd(a, d);
    check(d, exp, msg);
  endtask : rd_chk

  task automatic clash_evt(input logic col, input logic err, input logic [7:0] pos);
    @(posedge clk);
    collision_valid <= col;
    error_valid     <= err;
    bit_position    <= pos;
    @(posedge clk);
    collision_valid <= 1'b0;
    error_valid     <= 1'b0;
    bit_position    <= ~pos;
  endtask : clash_evt

  task automatic codes(input logic rx, input logic tx, input logic [2:0] p, input logic [2:0] s);
    @(posedge clk);
    rx_start                <= rx;
    tx_start                <= tx;
    primary_receive_input   <= p;
    secondary_receive_input <= s;
  endtask : codes

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    errors = 0;
    n_checks = 0;
    srst = 1'b1;
    chip_enable_pin = 1'b1;
    type_a_mode = 1'b1;
    collision_valid = 1'b0;
    error_valid = 1'b0;
    bit_position = 8'h00;
    tx_start = 1'b0;
    rx_start = 1'b0;
    primary_receive_input = 3'h0;
    secondary_receive_input = 3'h0;
    swap_inputs = 1'b0;
    agc_level = 3'h3;
    osc_running_pin = 1'b1;
    onoff_keying_pin = 1'b0;
    rx_subcarrier = 1'b1;
    tx_modulation = 1'b0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // Reset values and oscillator flag
    rd_chk(rfid_status_pkg::STRENGTH_OFF, 8'h00, "osc early");
    repeat (8) @(posedge clk);
    rd_chk(rfid_status_pkg::CLASH_OFF, 8'h00, "clash reset");
    rd_chk(rfid_status_pkg::TEST_OFF, 8'h00, "test reset");
    repeat (OSC_CYC + 10) @(posedge clk);
    rd_chk(rfid_status_pkg::STRENGTH_OFF, 8'h40, "osc stable");
    host_reg_model_inst.wr(rfid_status_pkg::STRENGTH_OFF, 8'hFF);
    rd_chk(rfid_status_pkg::STRENGTH_OFF, 8'h40, "ro write");
    host_reg_model_inst.wr(5'h05, 8'hFF);
    rd_chk(5'h05, 8'h00, "unmapped");
    $display("Test reset and status done");
    // Clash position, both protocol kinds
    clash_evt(1'b1, 1'b0, 8'hA5);
    rd_chk(rfid_status_pkg::CLASH_OFF, 8'hA5, "collision pos");
    rd_chk(rfid_status_pkg::CLASH_OFF, 8'h00, "clear on read");
    clash_evt(1'b0, 1'b1, 8'h11);
    rd_chk(rfid_status_pkg::CLASH_OFF, 8'h00, "error ignored type A");
    type_a_mode <= 1'b0;
    clash_evt(1'b0, 1'b1, 8'h3C);
    clash_evt(1'b1, 1'b0, 8'h81);
    rd_chk(rfid_status_pkg::CLASH_OFF, 8'h3C, "error pos");
    $display("Test clash done");
    // Every test bit alone, with pin routing
    for (int i = 0; i < 8; i++) begin
      host_reg_model_inst.wr(rfid_status_pkg::TEST_OFF, 8'h01 << i);
      repeat (6) @(posedge clk);
      check(outs, 8'h01 << i, "test outputs");
      check({7'h00, receiver_reset}, {7'h00, i == 5}, "rx reset");
      check({7'h00, keying_control_pin}, {7'h00, i == 6}, "keying pin");
      check({7'h00, decoder_data}, {7'h00, i != 7}, "decoder input");
      rd_chk(rfid_status_pkg::TEST_OFF, 8'h01 << i, "test readback");
    end
    host_reg_model_inst.wr(rfid_status_pkg::TEST_OFF, 8'h00);
    $display("Test analog control done");
    // Peak latch, window, clear and swap
    codes(1'b1, 1'b0, 3'h2, 3'h4);
    codes(1'b0, 1'b0, 3'h5, 3'h1);
    codes(1'b0, 1'b0, 3'h3, 3'h0);
    rd_chk(rfid_status_pkg::STRENGTH_OFF, 8'h65, "peaks");
    codes(1'b0, 1'b1, 3'h0, 3'h0);
    codes(1'b0, 1'b0, 3'h6, 3'h6);
    codes(1'b0, 1'b0, 3'h0, 3'h0);
    rd_chk(rfid_status_pkg::STRENGTH_OFF, 8'h40, "cleared at transmit");
    swap_inputs <= 1'b1;
    codes(1'b1, 1'b0, 3'h7, 3'h2);
    codes(1'b0, 1'b0, 3'h0, 3'h0);
    rd_chk(rfid_status_pkg::STRENGTH_OFF, 8'h7F, "swapped aux");
    host_reg_model_inst.wr(rfid_status_pkg::TEST_OFF, 8'h01);
    rd_chk(rfid_status_pkg::STRENGTH_OFF, 8'h7B, "gain level shown");
    $display("Test strength done");
    // Chip disable clears contents
    clash_evt(1'b0, 1'b1, 8'h77);
    chip_enable_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chip_enable_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(rfid_status_pkg::TEST_OFF, 8'h00, "test after disable");
    rd_chk(rfid_status_pkg::CLASH_OFF, 8'h00, "clash after disable");
    rd_chk(rfid_status_pkg::STRENGTH_OFF, 8'h00, "strength after disable");
    $display("Test disable done");
    final_report();
  end
endmodule : rfid_status_test_regs_tb_top
